// [verilog/bcso_pkg.sv]
/*
  bcso_pkg: constants and carrier types for the bus cycle status outputs.
  Assumes one 40 MHz clock and an internal bus sequencer that supplies
  cycle requests as a packed struct.
*/
`default_nettype none
package bcso_pkg;

  // ------------------------------------------------------------
  // cycle status codes
  // ------------------------------------------------------------
  localparam logic [2:0] ST_INTA  = 3'h0;
  localparam logic [2:0] ST_IORD  = 3'h1;
  localparam logic [2:0] ST_IOWR  = 3'h2;
  localparam logic [2:0] ST_HALT  = 3'h3;
  localparam logic [2:0] ST_FETCH = 3'h4;
  localparam logic [2:0] ST_MEMRD = 3'h5;
  localparam logic [2:0] ST_MEMWR = 3'h6;
  localparam logic [2:0] ST_PASS  = 3'h7;

  // ------------------------------------------------------------
  // queue status codes {high, low}
  // ------------------------------------------------------------
  localparam logic [1:0] QS_NONE  = 2'h0;
  localparam logic [1:0] QS_FIRST = 2'h1;
  localparam logic [1:0] QS_NEXT  = 2'h3;
  localparam logic [1:0] QS_EMPTY = 2'h2;

  // ------------------------------------------------------------
  // field layout and timing
  // ------------------------------------------------------------
  localparam int ADDR_W       = 20;
  localparam int UPPER_LSB    = 16;
  localparam int MID_LSB      = 8;
  localparam int DATA_PHASE_T = 2;   // data phase clocks before idle

  typedef enum logic [1:0] {
    BCSO_KIND_CPU,
    BCSO_KIND_DMA,
    BCSO_KIND_REFRESH
  } bcso_kind_t;

  // one bus cycle request from the sequencer
  typedef struct packed {
    logic [19:0] addr;
    logic [2:0]  status;
    bcso_kind_t  kind;
    logic        word;    // 16-bit transfer when a0 is zero
  } bcso_req_t;

  // pin values toward the pads
  typedef struct packed {
    logic [3:0] upper_address_lines;
    logic       upper_address_oe;
    logic [7:0] mid_address;
    logic [2:0] cycle_status_code;
    logic       status_oe;
    logic       ale_qs_low;
    logic       wr_qs_high;
    logic       upper_byte_enable_n;
    logic       byte_enable_oe;
    logic       read_strobe_n;
    logic       read_strobe_oe;
  } bcso_pins_t;

endpackage : bcso_pkg
`default_nettype wire

// [verilog/bcso_encode.sv]
/*
  bcso_encode: pure decode of a cycle request into byte-enable and
  status-derived strobes. Assumes the caller registers its outputs.
*/
`timescale 1ns/1ps
`default_nettype none
module bcso_encode
  import bcso_pkg::*;
(
  // request
  input  wire bcso_req_t req,
  input  wire logic      bus8,
  // decoded
  output logic           byte_en_n,
  output logic           is_read,
  output logic           is_write
);

  // ------------------------------------------------------------
  // byte enable and strobe decode
  // ------------------------------------------------------------
  always_comb
  begin
    if (bus8)
      byte_en_n = (req.kind == BCSO_KIND_REFRESH) ? 1'b0 : 1'b1;
    else if (req.kind == BCSO_KIND_REFRESH)
      byte_en_n = 1'b1;                       // a0=1,be=1 refresh
    else if (req.addr[0])
      byte_en_n = 1'b0;                       // odd byte
    else
      byte_en_n = req.word ? 1'b0 : 1'b1;     // word or even byte
    is_read  = (req.status == ST_IORD) || (req.status == ST_MEMRD)
               || (req.status == ST_FETCH) || (req.status == ST_INTA);
    is_write = (req.status == ST_IOWR) || (req.status == ST_MEMWR);
  end

endmodule : bcso_encode
`default_nettype wire

// [verilog/bcso_top.sv]
/*
  bcso_top: sequences address, status and strobe pins of the local bus.
  Assumes the sequencer holds req_valid until req_ready, and that
  hold, powerdown and queue status inputs are synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module bcso_top
  import bcso_pkg::*;
(
  // clock and reset
  input  wire  logic       clk,
  input  wire  logic       sys_rst,
  // configuration
  input  wire  logic       bus8,
  input  wire  logic       read_pin_in,
  // cycle requests
  input  wire  bcso_req_t  req,
  input  wire  logic       req_valid,
  output logic             req_ready,
  // bus state
  input  wire  logic       bus_hold,
  input  wire  logic       powerdown,
  input  wire  logic [1:0] queue_status,
  // pins
  output bcso_pins_t       pins,
  output logic             queue_mode
);

  typedef enum logic [1:0] {
    BCSO_IDLE,
    BCSO_ADDR,
    BCSO_DATA
  } bcso_state_t;

  bcso_state_t state_reg, state_next;
  bcso_req_t   cur_reg, cur_next;
  logic [1:0]  cnt_reg, cnt_next;
  logic        strap_done_reg, strap_done_next;
  logic        qmode_reg, qmode_next;
  bcso_pins_t  pins_reg, pins_next;
  logic        be_n, rd, wr;

  bcso_encode u_enc (
    .req      (cur_reg),
    .bus8     (bus8),
    .byte_en_n(be_n),
    .is_read  (rd),
    .is_write (wr)
  );

  assign req_ready  = (state_reg == BCSO_IDLE) && !bus_hold && !powerdown;
  assign pins       = pins_reg;
  assign queue_mode = qmode_reg;

  // ------------------------------------------------------------
  // strap capture: first clock after reset release samples the pin
  // ------------------------------------------------------------
  always_comb
  begin
    strap_done_next = 1'b1;
    qmode_next      = qmode_reg;
    if (!strap_done_reg)
      qmode_next = !read_pin_in;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      strap_done_reg <= 1'b0;
      qmode_reg      <= 1'b0;
    end
    else
    begin
      strap_done_reg <= strap_done_next;
      qmode_reg      <= qmode_next;
    end
  end

  // ------------------------------------------------------------
  // cycle sequencer: one address clock, then a fixed data phase
  // ------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    cur_next   = cur_reg;
    cnt_next   = cnt_reg;
    unique case (state_reg)
      BCSO_IDLE:
      begin
        if (req_valid && req_ready)
        begin
          cur_next   = req;
          state_next = BCSO_ADDR;
        end
      end
      BCSO_ADDR:
      begin
        cnt_next   = 2'(DATA_PHASE_T - 1);
        state_next = BCSO_DATA;
      end
      BCSO_DATA:
      begin
        if (cnt_reg == 2'h0)
          state_next = BCSO_IDLE;
        else
          cnt_next = cnt_reg - 2'h1;
      end
      // the fourth state code is unused; an upset there falls back to idle
      default:
        state_next = BCSO_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_reg <= BCSO_IDLE;
      cur_reg   <= '0;
      cnt_reg   <= 2'h0;
    end
    else
    begin
      state_reg <= state_next;
      cur_reg   <= cur_next;
      cnt_reg   <= cnt_next;
    end
  end

  // ------------------------------------------------------------
  // pin values, registered so pads see glitch-free levels
  // ------------------------------------------------------------
  always_comb
  begin
    pins_next                     = '0;
    pins_next.cycle_status_code   = ST_PASS;
    pins_next.upper_byte_enable_n = 1'b1;
    pins_next.read_strobe_n       = 1'b1;
    pins_next.wr_qs_high          = 1'b1;
    pins_next.upper_address_oe    = 1'b1;
    pins_next.status_oe           = 1'b1;
    pins_next.byte_enable_oe      = 1'b1;
    pins_next.read_strobe_oe      = 1'b1;
    if (state_next == BCSO_ADDR)
    begin
      pins_next.upper_address_lines =
        cur_next.addr[ADDR_W-1:UPPER_LSB];
      pins_next.cycle_status_code   = cur_next.status;
      pins_next.ale_qs_low          = 1'b1;
    end
    if (state_reg != BCSO_IDLE && state_next == BCSO_DATA)
    begin
      // bit 3 carries the source flag; 18..16 forced zero
      pins_next.upper_address_lines =
        {(cur_reg.kind != BCSO_KIND_CPU), 3'h0};
      pins_next.cycle_status_code   = cur_reg.status;
      pins_next.read_strobe_n       = !rd;
      pins_next.wr_qs_high          = !wr;
    end
    if (state_next != BCSO_IDLE)
    begin
      // address 15..8 stays valid for the whole cycle on 8-bit bus
      pins_next.mid_address = bus8 ?
        cur_next.addr[UPPER_LSB-1:MID_LSB] : 8'h00;
      pins_next.upper_byte_enable_n = be_n;
      if (state_reg == BCSO_IDLE)
        pins_next.upper_byte_enable_n = 1'b1;
    end
    if (qmode_reg)
    begin
      // queue status replaces latch strobe and write strobe
      pins_next.ale_qs_low = queue_status[0];
      pins_next.wr_qs_high = queue_status[1];
    end
    if (bus_hold)
    begin
      pins_next.upper_address_oe = 1'b0;
      pins_next.status_oe        = 1'b0;
      pins_next.byte_enable_oe   = 1'b0;
      pins_next.read_strobe_oe   = 1'b0;
    end
    if (bus_hold || powerdown)
      pins_next.ale_qs_low = 1'b0;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      // reset floats the bus outputs and holds the strobe low
      pins_reg                     <= '0;
      pins_reg.cycle_status_code   <= ST_PASS;
      pins_reg.upper_byte_enable_n <= 1'b1;
      pins_reg.read_strobe_n       <= 1'b1;
      pins_reg.wr_qs_high          <= 1'b1;
    end
    else
      pins_reg <= pins_next;
  end

endmodule : bcso_top
`default_nettype wire

// [test/bcso_sva.sv]
/* bcso_sva: port checker for bcso_top.
   assumes a bind onto bcso_top and the single clk domain. */
`timescale 1ns/1ps
`default_nettype none
module bcso_sva
  import bcso_pkg::*;
(
  // clock and reset
  input wire logic       clk,
  input wire logic       sys_rst,
  // requests and bus state
  input wire logic       bus8,
  input wire bcso_req_t  req,
  input wire logic       req_valid,
  input wire logic       req_ready,
  input wire logic       bus_hold,
  input wire logic       powerdown,
  input wire logic [1:0] queue_status,
  // pins
  input wire bcso_pins_t pins,
  input wire logic       queue_mode
);
  // ----------------------------------------------------------
  // properties
  // ----------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic tk;
  // a request is taken on this edge
  assign tk = req_valid && req_ready;
  sequence s_data;
    (pins.upper_address_lines[2:0] == 3'h0) [*2];
  endsequence
  sequence s_addr;
    pins.ale_qs_low && pins.upper_address_lines == $past(req.addr[19:16]);
  endsequence
  AST_ADDR: assert property (tk && !queue_mode |=> s_addr)
    else $error("address phase wrong");
  AST_DATA: assert property (tk |=> ##1 s_data)
    else $error("upper lines not zero");
  AST_FLAG: assert property (tk |-> ##2 pins.upper_address_lines[3] ==
    ($past(req.kind, 2) != BCSO_KIND_CPU)) else $error("source flag");
  AST_STAT: assert property (tk |=>
    pins.cycle_status_code == $past(req.status) ##1
    ($stable(pins.cycle_status_code)) [*2] ##1
    pins.cycle_status_code == ST_PASS) else $error("status code");
  AST_MID: assert property (bus8 && tk |=>
    pins.mid_address == $past(req.addr[15:8]) ##1
    ($stable(pins.mid_address)) [*2]) else $error("mid address");
  AST_REFRESH: assert property (bus8 && tk && req.kind ==
    BCSO_KIND_REFRESH |-> ##2 !pins.upper_byte_enable_n)
    else $error("refresh mark");
  AST_RD: assert property (tk && req.status == ST_MEMRD |->
    ##2 (!pins.read_strobe_n) [*2]) else $error("read strobe");
  AST_QS: assert property (queue_mode && !bus_hold && !powerdown |=>
    {pins.wr_qs_high, pins.ale_qs_low} == $past(queue_status))
    else $error("queue status");
  AST_HOLD: assert property (bus_hold [*5] |-> !(pins.upper_address_oe
    || pins.status_oe || pins.byte_enable_oe || pins.read_strobe_oe))
    else $error("hold float");
  AST_ALE: assert property ((bus_hold || powerdown) [*5] |->
    !pins.ale_qs_low) else $error("latch strobe high");
endmodule : bcso_sva
`default_nettype wire

// [test/bcso_far.sv]
/* bcso_far: external address latch and read pad with strap.
   assumes pins of bcso_top; strap_gnd grounds the pad. */
`timescale 1ns/1ps
`default_nettype none
module bcso_far
  import bcso_pkg::*;
(
  // pad side
  input  wire bcso_pins_t pins,
  input  wire logic       queue_mode,
  input  wire logic       strap_gnd,
  // toward core and bench
  output logic            read_pin,
  output logic [3:0]      latched_upper
);
  // released pad sits at the weak pull-up unless grounded
  always_comb
    read_pin = pins.read_strobe_oe ? pins.read_strobe_n : !strap_gnd;
  // transparent latch: follows while the strobe is high
  always_latch
    if (pins.ale_qs_low && !queue_mode)
      latched_upper = pins.upper_address_lines;
endmodule : bcso_far
`default_nettype wire

// [test/tb_top.sv]
/* tb_top: self-checking bench for bcso_top.
   assumes bcso_far as the board side and bcso_sva bound below. */
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import bcso_pkg::*;
();
  logic clk, sys_rst, bus8, rd_pin, req_valid, req_ready, bus_hold;
  logic powerdown, strap_gnd, queue_mode;
  logic [1:0] queue_status;
  logic [3:0] lat;
  logic [19:0] a;
  bcso_kind_t k;
  bcso_req_t req;
  bcso_pins_t pins;
  int bad_count, comparisons, seed, i;
  // reference model: addresses the board latch should capture, in order
  int exp_q[$];
  bcso_top u_dut (.clk, .sys_rst, .bus8, .read_pin_in(rd_pin), .req,
    .req_valid, .req_ready, .bus_hold, .powerdown, .queue_status,
    .pins, .queue_mode);
  bcso_far u_far (.pins, .queue_mode, .strap_gnd, .read_pin(rd_pin),
    .latched_upper(lat));
  // 40 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [19:0] g, input logic [19:0] e);
    comparisons++;
    if (g !== e)
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    if (g !== e)
      bad_count++;
  endtask : chk
  task automatic final_report;
    if (bad_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report
  // one bus cycle; expectations come from the kind, status, address, word flag and bus width
  task automatic cyc(input logic [2:0] st, input logic w);
    int n;
    logic rd, wr, nb;
    req = '{addr: a, status: st, kind: k, word: w};
    req_valid = 1'b1;
    exp_q.push_back(int'(a[19:16]));
    rd = st inside {ST_IORD, ST_FETCH, ST_MEMRD};
    wr = st inside {ST_IOWR, ST_MEMWR};
    nb = bus8 ? k != BCSO_KIND_REFRESH
      : k == BCSO_KIND_REFRESH || (!a[0] && !w);
    for (n = 0; n < 50 && req_ready !== 1'b1; n++)
      @(negedge clk);
    if (n == 50)
    begin
      $display("CHECK FAILED t=%0t ready timeout", $time);
      bad_count++;
      final_report;
    end
    @(negedge clk);
    req_valid = 1'b0;
    chk(20'(pins.ale_qs_low), 20'h1);
    chk(20'(pins.upper_address_lines), 20'(a[19:16]));
    if (bus8) chk(20'(pins.mid_address), 20'(a[15:8]));
    repeat (2)
    begin
      @(negedge clk);
      chk(20'(pins.upper_address_lines), {16'h0, k != 0, 3'h0});
      chk(20'(pins.cycle_status_code), 20'(st));
      chk(20'(pins.upper_byte_enable_n), 20'(nb));
      // strobes stay idle in halt and passive cycles too
      if (st != ST_INTA) chk(20'({pins.read_strobe_n, pins.wr_qs_high}),
        20'({!rd, !wr}));
    end
    chk(20'(lat), 20'(exp_q.pop_front()));
  endtask : cyc
  // reset, every code in both widths, hold, powerdown, queue mode
  initial
  begin
    seed = 20;
    {sys_rst, bus8, req_valid, bus_hold, powerdown, strap_gnd} = 6'h20;
    queue_status = 2'h0;
    req = '0;
    bad_count = 0;
    comparisons = 0;
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    chk(20'(queue_mode), 20'h0);
    for (i = 0; i < 48; i++)
    begin
      bus8 = i >= 24;
      a = 20'($random(seed));
      k = bcso_kind_t'(i % 3);
      if (k == BCSO_KIND_REFRESH) a[0] = 1'b1;
      cyc(3'(i), 1'($random(seed)));
    end
    req_valid = 1'b1;
    bus_hold = 1'b1;
    repeat (6) @(negedge clk);
    chk(20'({pins.upper_address_oe, pins.status_oe, pins.byte_enable_oe,
      pins.read_strobe_oe, pins.ale_qs_low, req_ready}), 20'h0);
    {req_valid, bus_hold, powerdown} = 3'h1;
    repeat (6) @(negedge clk);
    chk(20'({pins.ale_qs_low, req_ready}), 20'h0);
    {powerdown, sys_rst, strap_gnd} = 3'h3;
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    strap_gnd = 1'b0;
    chk(20'(queue_mode), 20'h1);
    for (i = 0; i < 4; i++)
    begin
      queue_status = 2'(i);
      @(negedge clk);
      chk(20'({pins.wr_qs_high, pins.ale_qs_low}), 20'(i));
    end
    final_report;
  end
endmodule : tb_top
bind bcso_top bcso_sva u_sva (.clk, .sys_rst, .bus8, .req, .req_valid,
  .req_ready, .bus_hold, .powerdown, .queue_status, .pins, .queue_mode);
`default_nettype wire
